/* File: include/rco_pkg.sv */
package rco_pkg;

   // Register indices; byte address is four times the index
   localparam logic [6:0] IDX_RADIO_CTL = 7'h02;
   localparam logic [6:0] IDX_TRAFFIC   = 7'h06;
   localparam logic [6:0] IDX_EXT_PWR   = 7'h2D;
   localparam logic [6:0] IDX_DLY_HI    = 7'h49;
   localparam logic [6:0] IDX_DLY_LO    = 7'h4A;
   localparam logic [6:0] IDX_WID_HI    = 7'h4B;
   localparam logic [6:0] IDX_WID_LO    = 7'h4C;
   localparam logic [6:0] IDX_BAND_CTL  = 7'h50;
   localparam logic [6:0] IDX_OVERRIDE  = 7'h51;
   localparam logic [6:0] IDX_SYN_RX    = 7'h52;
   localparam logic [6:0] IDX_SYN_TX    = 7'h53;
   localparam logic [6:0] IDX_SYN_MON   = 7'h54;
   localparam logic [6:0] IDX_STATUS    = 7'h55;

   // Field positions
   localparam int RC_TXEN    = 0;
   localparam int RC_RXEN    = 1;
   localparam int RC_MONEN   = 2;
   localparam int RC_PLL_EN  = 3;
   localparam int RC_PLL_POL = 6;
   localparam int TM_PA_POL  = 7;
   localparam int EP_RADIO   = 1;
   localparam int BC_BAND_EN = 0;
   localparam int BC_SECOND  = 1;
   localparam int OV_SEL_LSB = 0;
   localparam int OV_VAL_LSB = 4;

   // Reset values
   localparam logic [7:0]  RST_BYTE = 8'h00;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;

   // Word being serialized for synthesizer 1
   localparam logic [1:0] SYN_SEL_RX  = 2'h0;
   localparam logic [1:0] SYN_SEL_TX  = 2'h1;
   localparam logic [1:0] SYN_SEL_MON = 2'h2;

   // AHB codes
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam logic       HRESP_OK   = 1'h0;

   typedef enum logic [1:0] {
      PA_IDLE,
      PA_DELAY,
      PA_WIDTH
   } rco_pa_state_e;

   typedef struct packed {
      logic band_select_primary;
      logic band_select_secondary;
      logic radio_power_pin;
      logic tx_pll_switch;
      logic transmit_enable_pin;
      logic power_amp_enable;
      logic receive_on_pin;
      logic synth_one_enable_pin;
      logic gain_select_a;
      logic gain_select_b;
   } rco_pins_s;

endpackage : rco_pkg

/* File: verilog/rco_top.sv */
// Design decisions made here: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
module rco_top (
   input  wire logic             clock,
   input  wire logic             rst,
   input  wire logic             hsel,
   input  wire logic [31:0]      haddr,
   input  wire logic [1:0]       htrans,
   input  wire logic             hwrite,
   input  wire logic [2:0]       hsize,
   input  wire logic             hready,
   input  wire logic [31:0]      hwdata,
   output logic      [31:0]      hrdata,
   output logic                  hreadyout,
   output logic                  hresp,
   input  wire logic             serialize_start,
   input  wire logic [1:0]       serialize_word,
   input  wire logic             quarter_bit_tick,
   input  wire logic             gpio1_out,
   input  wire logic             gpio2_out,
   input  wire logic             synth_one_enable_in,
   input  wire logic             gain_select_a_in,
   input  wire logic             gain_select_b_in,
   output rco_pkg::rco_pins_s    radio_pins
);
   import rco_pkg::*;

   // Bus address phase capture
   logic                 wr_pend_r;
   logic [6:0]           wr_idx_r;
   logic [31:0]          hrdata_r;
   wire  logic           addr_ok, addr_map, wr_go;
   wire  logic [6:0]     addr_idx;
   // Software registers
   logic [7:0]           radio_ctl_r, traffic_r, ext_pwr_r;
   logic [7:0]           dly_hi_r, dly_lo_r, wid_hi_r, wid_lo_r;
   logic [7:0]           band_ctl_r, override_r;
   logic [31:0]          syn_rx_r, syn_tx_r, syn_mon_r, rd_mux;
   // Block state
   logic                 band_raw_r, tx_prev_r;
   rco_pa_state_e        pa_state_r, pa_state_nxt;
   logic [9:0]           pa_cnt_r, pa_cnt_nxt;
   rco_pins_s            pins_r, pins_nxt;
   // Decoded controls
   wire  logic           radio_on, band_en, second_en, tx_flag, tx_rise;
   wire  logic           pa_pol, pa_active, band_bit;
   wire  logic [9:0]     pa_dly, pa_wid;
   wire  logic [2:0]     ov_sel, ov_val;
   wire  logic           bsp_nxt, bss_nxt, pll_nxt;
   wire  logic           syn1_nxt, gain_a_nxt, gain_b_nxt;

   // Only whole-word aligned transfers inside the window are mapped
   assign addr_ok  = hsel & hready & htrans[1];
   assign addr_map = (haddr[31:9] == 23'h000000) &
                     (haddr[1:0] == 2'h0) & (hsize == HSIZE_WORD);
   assign addr_idx = haddr[8:2];
   assign wr_go    = addr_ok & hwrite & addr_map;

   // Zero wait state slave, always OKAY
   assign hreadyout = 1'h1;
   assign hresp     = HRESP_OK;
   assign hrdata    = hrdata_r;

   // Capture write target for the data phase
   always_ff @(posedge clock) begin
      if (rst) begin
         wr_pend_r <= 1'h0;
         wr_idx_r  <= 7'h00;
      end else begin
         wr_pend_r <= wr_go;
         wr_idx_r  <= wr_go ? addr_idx : wr_idx_r;
      end
   end

   // Read data sampled in address phase; unmapped reads zero
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (addr_idx)
         IDX_RADIO_CTL: rd_mux = {24'h000000, radio_ctl_r};
         IDX_TRAFFIC:   rd_mux = {24'h000000, traffic_r};
         IDX_EXT_PWR:   rd_mux = {24'h000000, ext_pwr_r};
         IDX_DLY_HI:    rd_mux = {24'h000000, dly_hi_r};
         IDX_DLY_LO:    rd_mux = {24'h000000, dly_lo_r};
         IDX_WID_HI:    rd_mux = {24'h000000, wid_hi_r};
         IDX_WID_LO:    rd_mux = {24'h000000, wid_lo_r};
         IDX_BAND_CTL:  rd_mux = {24'h000000, band_ctl_r};
         IDX_OVERRIDE:  rd_mux = {24'h000000, override_r};
         IDX_SYN_RX:    rd_mux = syn_rx_r;
         IDX_SYN_TX:    rd_mux = syn_tx_r;
         IDX_SYN_MON:   rd_mux = syn_mon_r;
         IDX_STATUS:    rd_mux = {29'h00000000,
                                  pa_state_r == PA_WIDTH,
                                  pa_state_r == PA_DELAY,
                                  band_raw_r};
         default:       rd_mux = 32'h0000_0000;
      endcase
      if (!addr_map) begin
         rd_mux = 32'h0000_0000;
      end
   end

   // Read data register; a read right after a write sees old data
   always_ff @(posedge clock) begin
      if (rst) begin
         hrdata_r <= 32'h0000_0000;
      end else if (addr_ok & ~hwrite) begin
         hrdata_r <= rd_mux;
      end
   end

   // Byte registers, written in the data phase
   always_ff @(posedge clock) begin
      if (rst) begin
         radio_ctl_r <= RST_BYTE;
         traffic_r   <= RST_BYTE;
         ext_pwr_r   <= RST_BYTE;
         dly_hi_r    <= RST_BYTE;
         dly_lo_r    <= RST_BYTE;
         wid_hi_r    <= RST_BYTE;
         wid_lo_r    <= RST_BYTE;
         band_ctl_r  <= RST_BYTE;
         override_r  <= RST_BYTE;
      end else if (wr_pend_r) begin
         case (wr_idx_r)
            IDX_RADIO_CTL: radio_ctl_r <= hwdata[7:0];
            IDX_TRAFFIC:   traffic_r   <= hwdata[7:0];
            IDX_EXT_PWR:   ext_pwr_r   <= hwdata[7:0];
            IDX_DLY_HI:    dly_hi_r    <= hwdata[7:0];
            IDX_DLY_LO:    dly_lo_r    <= hwdata[7:0];
            IDX_WID_HI:    wid_hi_r    <= hwdata[7:0];
            IDX_WID_LO:    wid_lo_r    <= hwdata[7:0];
            IDX_BAND_CTL:  band_ctl_r  <= hwdata[7:0];
            IDX_OVERRIDE:  override_r  <= hwdata[7:0];
            default:       ;
         endcase
      end
   end

   // Synthesizer 1 words for Rx, Tx and Monitor
   always_ff @(posedge clock) begin
      if (rst) begin
         syn_rx_r  <= RST_WORD;
         syn_tx_r  <= RST_WORD;
         syn_mon_r <= RST_WORD;
      end else if (wr_pend_r) begin
         case (wr_idx_r)
            IDX_SYN_RX:  syn_rx_r  <= hwdata;
            IDX_SYN_TX:  syn_tx_r  <= hwdata;
            IDX_SYN_MON: syn_mon_r <= hwdata;
            default:     ;
         endcase
      end
   end

   // Control field decode
   assign radio_on  = ext_pwr_r[EP_RADIO];
   assign band_en   = band_ctl_r[BC_BAND_EN];
   assign second_en = band_ctl_r[BC_SECOND];
   assign tx_flag   = radio_ctl_r[RC_TXEN];
   assign pa_pol    = traffic_r[TM_PA_POL];
   assign ov_sel    = override_r[OV_SEL_LSB +: 3];
   assign ov_val    = override_r[OV_VAL_LSB +: 3];

   assign pa_dly    = {dly_hi_r[1:0], dly_lo_r};
   assign pa_wid    = {wid_hi_r[1:0], wid_lo_r};

   // bit0 of the word being shifted out
   assign band_bit = (serialize_word == SYN_SEL_TX)  ? syn_tx_r[0] :
                     (serialize_word == SYN_SEL_MON) ? syn_mon_r[0] :
                     syn_rx_r[0];

   // hold until the next word goes out
   always_ff @(posedge clock) begin
      if (rst) begin
         band_raw_r <= 1'h0;
      end else if (serialize_start) begin
         band_raw_r <= band_bit;
      end
   end

   assign tx_rise = tx_flag & ~tx_prev_r;

   always_ff @(posedge clock) begin
      if (rst) begin
         tx_prev_r <= 1'h0;
      end else begin
         tx_prev_r <= tx_flag;
      end
   end

   // PA pulse sequencer; a new edge restarts it, or returns it to idle when the width is zero
   always_comb begin
      pa_state_nxt = pa_state_r;
      pa_cnt_nxt   = pa_cnt_r;
      if (tx_rise) begin
         pa_state_nxt = (pa_wid == 10'h000) ? PA_IDLE : PA_DELAY;
         pa_cnt_nxt   = pa_dly;
      end else begin
         case (pa_state_r)
            PA_IDLE: begin
               pa_cnt_nxt = 10'h000;
            end
            PA_DELAY: begin
               if (pa_cnt_r == 10'h000) begin
                  pa_state_nxt = PA_WIDTH;
                  pa_cnt_nxt   = pa_wid;
               end else if (quarter_bit_tick) begin
                  pa_cnt_nxt = pa_cnt_r - 10'h001;
               end
            end
            PA_WIDTH: begin
               if (pa_cnt_r == 10'h000) begin
                  pa_state_nxt = PA_IDLE;
               end else if (quarter_bit_tick) begin
                  pa_cnt_nxt = pa_cnt_r - 10'h001;
               end
            end
            default: begin
               pa_state_nxt = PA_IDLE;
               pa_cnt_nxt   = 10'h000;
            end
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         pa_state_r <= PA_IDLE;
         pa_cnt_r   <= 10'h000;
      end else begin
         pa_state_r <= pa_state_nxt;
         pa_cnt_r   <= pa_cnt_nxt;
      end
   end

   assign pa_active = (pa_state_r == PA_WIDTH);

   assign bsp_nxt = band_en ? (band_raw_r & radio_on) : gpio2_out;

   // inverse of the ungated band value
   assign bss_nxt = (band_en & second_en) ? (~band_raw_r & radio_on)
                                          : gpio1_out;

   // enable xor polarity gives the level
   assign pll_nxt = radio_ctl_r[RC_PLL_EN] ^ radio_ctl_r[RC_PLL_POL];

   // radio function while select is clear
   assign syn1_nxt   = ov_sel[0] ? ov_val[0] : synth_one_enable_in;
   assign gain_a_nxt = ov_sel[1] ? ov_val[1] : gain_select_a_in;
   assign gain_b_nxt = ov_sel[2] ? ov_val[2] : gain_select_b_in;

   // Pin bundle assembly
   assign pins_nxt = '{
      band_select_primary:   bsp_nxt,
      band_select_secondary: bss_nxt,
      // direct copy of the power flag
      radio_power_pin:       radio_on,
      tx_pll_switch:         pll_nxt,
      transmit_enable_pin:   tx_flag,
      power_amp_enable:      pa_active ^ pa_pol,
      receive_on_pin:        radio_ctl_r[RC_RXEN] |
                             radio_ctl_r[RC_MONEN],
      synth_one_enable_pin:  syn1_nxt,
      gain_select_a:         gain_a_nxt,
      gain_select_b:         gain_b_nxt
   };

   // Registered pins so they never glitch on decode changes
   always_ff @(posedge clock) begin
      if (rst) begin
         pins_r <= '0;
      end else begin
         pins_r <= pins_nxt;
      end
   end

   assign radio_pins = pins_r;

   // Checks on the pin logic; held off one cycle past reset release,
   // since an attempt begun on the releasing edge sees reset state
   logic rst_d_r;
   always_ff @(posedge clock) begin
      rst_d_r <= rst;
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst || rst_d_r);
   property p_band_gpio;
      !band_en |=> pins_r.band_select_primary == $past(gpio2_out);
   endproperty
   a_band_gpio: assert property (p_band_gpio)
      else $error("primary band pin left gpio function");
   property p_band_sample;
      serialize_start && serialize_word == SYN_SEL_TX
         |=> band_raw_r == $past(syn_tx_r[0]);
   endproperty
   a_band_sample: assert property (p_band_sample)
      else $error("band bit not sampled from tx word");
   property p_band_hold;
      !serialize_start |=> $stable(band_raw_r);
   endproperty
   a_band_hold: assert property (p_band_hold)
      else $error("band bit changed without serialization");
   property p_band_power;
      band_en && !radio_on ##1 band_en && !radio_on
         |=> !pins_r.band_select_primary;
   endproperty
   a_band_power: assert property (p_band_power)
      else $error("primary band high with radio off");
   property p_band_second;
      band_en && second_en && radio_on
         |=> pins_r.band_select_secondary == !$past(band_raw_r);
   endproperty
   a_band_second: assert property (p_band_second)
      else $error("secondary band not inverse of primary");
   property p_override;
      ov_sel[1] |=> pins_r.gain_select_a == $past(ov_val[1]);
   endproperty
   a_override: assert property (p_override)
      else $error("override value not on gain pin a");
   property p_power_pin;
      $rose(radio_on) |=> pins_r.radio_power_pin;
   endproperty
   a_power_pin: assert property (p_power_pin)
      else $error("power pin missed radio power rise");
   property p_pll_off;
      !radio_ctl_r[RC_PLL_EN]
         |=> pins_r.tx_pll_switch == $past(radio_ctl_r[RC_PLL_POL]);
   endproperty
   a_pll_off: assert property (p_pll_off)
      else $error("pll switch active while disabled");
   property p_pa_start;
      tx_rise && pa_wid != 10'h000 && pa_dly == 10'h000
         |-> ##2 pa_state_r == PA_WIDTH ##1
             pins_r.power_amp_enable == !$past(pa_pol);
   endproperty
   a_pa_start: assert property (p_pa_start)
      else $error("pa pulse did not start after zero delay");
   property p_pa_zero;
      tx_rise && pa_wid == 10'h000 |=> pa_state_r == PA_IDLE;
   endproperty
   a_pa_zero: assert property (p_pa_zero)
      else $error("pa pulse started with zero width");
   property p_pa_step;
      pa_state_r == PA_DELAY && pa_cnt_r != 10'h000 &&
      quarter_bit_tick && !tx_rise
         |=> pa_cnt_r == $past(pa_cnt_r) - 10'h001;
   endproperty
   a_pa_step: assert property (p_pa_step)
      else $error("delay count did not step on tick");
   property p_pa_wait;
      pa_state_r == PA_WIDTH && pa_cnt_r != 10'h000 &&
      !quarter_bit_tick && !tx_rise
         |=> pa_state_r == PA_WIDTH && $stable(pa_cnt_r);
   endproperty
   a_pa_wait: assert property (p_pa_wait)
      else $error("width count moved without tick");
   property p_rx_on;
      radio_ctl_r[RC_MONEN] && !radio_ctl_r[RC_RXEN]
         |=> pins_r.receive_on_pin;
   endproperty
   a_rx_on: assert property (p_rx_on)
      else $error("receive-on low with monitor enabled");

endmodule : rco_top

/* File: tb/rco_rf_model.sv */
`timescale 1ns/100ps
// Far side: quarter-bit timebase source and PA pulse timing probe
module rco_rf_model #(
   parameter int TICK_PERIOD = 4
) (
   input  wire logic               clock,
   input  wire logic               rst,
   input  wire rco_pkg::rco_pins_s pins,
   input  wire logic               pa_pol,
   output logic                    tick,
   output logic [31:0]             lead_cycles,
   output logic [31:0]             len_cycles,
   output logic [31:0]             pulse_count
);
   import rco_pkg::*;

   logic [7:0]  tick_cnt_r;
   logic        tx_prev_r;
   logic        act_prev_r;
   logic [31:0] lead_cnt_r;
   logic [31:0] len_cnt_r;
   wire  logic  pa_act = pins.power_amp_enable ^ pa_pol;

   always_ff @(posedge clock) begin
      if (rst) begin
         tick_cnt_r <= 8'h00;
         tick       <= 1'b0;
      end else begin
         tick_cnt_r <= (tick_cnt_r == 8'(TICK_PERIOD - 1)) ? 8'h00
                       : tick_cnt_r + 8'h01;
         tick       <= (tick_cnt_r == 8'h00);
      end
   end

   // Lead from transmit rise, then active length in cycles
   always_ff @(posedge clock) begin
      if (rst) begin
         tx_prev_r   <= 1'b0;
         act_prev_r  <= 1'b0;
         lead_cnt_r  <= 32'h0;
         len_cnt_r   <= 32'h0;
         lead_cycles <= 32'h0;
         len_cycles  <= 32'h0;
         pulse_count <= 32'h0;
      end else begin
         tx_prev_r  <= pins.transmit_enable_pin;
         act_prev_r <= pa_act;
         lead_cnt_r <= (pins.transmit_enable_pin && !tx_prev_r) ? 32'h0
                       : lead_cnt_r + 32'h1;
         len_cnt_r  <= len_cnt_r + 32'h1;
         if (pa_act && !act_prev_r) begin
            lead_cycles <= lead_cnt_r + 32'h1;
            len_cnt_r   <= 32'h1;
         end
         if (!pa_act && act_prev_r) begin
            len_cycles  <= len_cnt_r;
            pulse_count <= pulse_count + 32'h1;
         end
      end
   end
endmodule : rco_rf_model

/* File: tb/tb.sv */
`timescale 1ns/100ps
module tb;
   import rco_pkg::*;
   localparam int TICK = 4;

   logic clock, rst, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans, serialize_word;
   logic [2:0]  hsize;
   logic serialize_start, quarter_bit_tick, gpio1_out, gpio2_out;
   logic syn_in, ga_in, gb_in, pa_pol;
   logic [31:0] lead_cycles, len_cycles, pulse_count;
   rco_pins_s pins;
   int n_errors = 0;
   int cmp_count = 0;

   assign hready = hreadyout;

   rco_top dut (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
      .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .serialize_start(serialize_start),
      .serialize_word(serialize_word), .quarter_bit_tick(quarter_bit_tick),
      .gpio1_out(gpio1_out), .gpio2_out(gpio2_out),
      .synth_one_enable_in(syn_in), .gain_select_a_in(ga_in),
      .gain_select_b_in(gb_in), .radio_pins(pins));

   rco_rf_model #(.TICK_PERIOD(TICK)) rf (.clock(clock), .rst(rst),
      .pins(pins), .pa_pol(pa_pol), .tick(quarter_bit_tick),
      .lead_cycles(lead_cycles), .len_cycles(len_cycles),
      .pulse_count(pulse_count));

   // Clock at 25 ns
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   task test_done;
      $display("mismatches %0d comparisons %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : test_done

   task automatic cmp(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp

   task automatic cmp_rng(input string what, input int lo, input int hi,
                          input logic [31:0] got);
      cmp_count++;
      if ((got >= 32'(lo) && got <= 32'(hi)) !== 1'b1) begin
         n_errors++;
         $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, got);
      end
   endtask : cmp_rng

   // One single AHB transfer; waits on hready in both phases
   task automatic ahb(input logic wr, input logic [6:0] idx,
                      input logic [31:0] wd, output logic [31:0] rd);
      @(posedge clock);
      hsel   <= 1'b1;
      haddr  <= {23'h000000, idx, 2'b00};
      htrans <= 2'b10;
      hwrite <= wr;
      hsize  <= HSIZE_WORD;
      do @(posedge clock); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge clock); while (hready !== 1'b1);
      rd = hrdata;
   endtask : ahb

   task automatic wr(input logic [6:0] idx, input logic [31:0] wd);
      logic [31:0] rd;
      ahb(1'b1, idx, wd, rd);
      repeat (2) @(posedge clock);
      #1;
   endtask : wr

   // words keep the band bit at bit 0, never shifted out
   task automatic ser(input logic [1:0] w);
      @(posedge clock);
      serialize_start <= 1'b1;
      serialize_word  <= w;
      @(posedge clock);
      serialize_start <= 1'b0;
      repeat (2) @(posedge clock);
      #1;
   endtask : ser

   task automatic s_regs;
      logic [31:0] rd;
      logic [6:0]  idx [7];
      idx = '{IDX_RADIO_CTL, IDX_TRAFFIC, IDX_EXT_PWR, IDX_DLY_HI,
              IDX_DLY_LO, IDX_WID_HI, IDX_WID_LO};
      cmp("band primary", 32'(gpio2_out),
          32'(pins.band_select_primary));
      cmp("band second", 32'(gpio1_out),
          32'(pins.band_select_secondary));
      cmp("hresp", 32'(HRESP_OK), 32'(hresp));
      cmp("synth1 en", 32'(syn_in), 32'(pins.synth_one_enable_pin));
      cmp("gain b", 32'(gb_in), 32'(pins.gain_select_b));
      // Byte registers keep only the low eight bits
      for (int i = 0; i < 7; i++) begin
         ahb(1'b0, idx[i], 32'h0, rd);
         cmp("reset value", 32'(RST_BYTE), rd);
         ahb(1'b1, idx[i], 32'h1234_56A5, rd);
         ahb(1'b0, idx[i], 32'h0, rd);
         cmp("readback", 32'h0000_00A5, rd);
         ahb(1'b1, idx[i], 32'h0, rd);
      end
      ahb(1'b1, 7'h7F, 32'hFFFF_FFFF, rd);
      ahb(1'b0, 7'h7F, 32'h0, rd);
      cmp("unmapped", 32'h0, rd);
   endtask : s_regs

   task automatic s_band;
      logic [2:0] bits;
      bits = 3'b101;
      wr(IDX_EXT_PWR, 32'h02);
      wr(IDX_BAND_CTL, 32'h01);
      wr(IDX_SYN_RX, 32'hFFFF_FFF1);
      wr(IDX_SYN_TX, 32'hFFFF_FFF0);
      wr(IDX_SYN_MON, 32'h0000_0001);
      for (int i = 0; i < 3; i++) begin
         ser(2'(i));
         cmp("band per word", 32'(bits[i]),
             32'(pins.band_select_primary));
      end
      wr(IDX_SYN_MON, 32'h0);
      cmp("band held", 32'h1, 32'(pins.band_select_primary));
      wr(IDX_BAND_CTL, 32'h03);
      cmp("second inv", 32'h0, 32'(pins.band_select_secondary));
      ser(SYN_SEL_MON);
      cmp("second inv", 32'h1, 32'(pins.band_select_secondary));
      wr(IDX_EXT_PWR, 32'h0);
      cmp("second off", 32'h0, 32'(pins.band_select_secondary));
      cmp("power pin", 32'h0, 32'(pins.radio_power_pin));
      ser(SYN_SEL_RX);
      cmp("primary off", 32'h0, 32'(pins.band_select_primary));
      wr(IDX_EXT_PWR, 32'h02);
      cmp("primary on", 32'h1, 32'(pins.band_select_primary));
      cmp("power pin", 32'h1, 32'(pins.radio_power_pin));
      // Band value is 1 here, so a low gpio level tells the two apart
      @(posedge clock);
      gpio2_out <= 1'b0;
      wr(IDX_BAND_CTL, 32'h0);
      cmp("gpio back", 32'h0, 32'(pins.band_select_primary));
   endtask : s_band

   task automatic s_ovr;
      logic [2:0] in, ex;
      in = {gb_in, ga_in, syn_in};
      for (int s = 0; s < 8; s++) begin
         wr(IDX_OVERRIDE, {25'h0, 3'b110, 1'b0, 3'(s)});
         ex = (3'b110 & 3'(s)) | (in & ~3'(s));
         cmp("override", 32'(ex), 32'({pins.gain_select_b,
             pins.gain_select_a, pins.synth_one_enable_pin}));
      end
      wr(IDX_OVERRIDE, 32'h0);
   endtask : s_ovr

   task automatic s_rctl;
      logic [31:0] c0;
      logic [4:0]  v;
      c0 = pulse_count;
      for (int i = 0; i < 32; i++) begin
         v = 5'(i);
         wr(IDX_RADIO_CTL, {24'h0, 1'b0, v[4], 2'b00, v[3:0]});
         cmp("pll switch", 32'(v[3] ^ v[4]),
             32'(pins.tx_pll_switch));
         cmp("tx pin", 32'(v[0]), 32'(pins.transmit_enable_pin));
         cmp("rx on", 32'(v[1] | v[2]), 32'(pins.receive_on_pin));
      end
      wr(IDX_RADIO_CTL, 32'h0);
      cmp("no pulse", c0, pulse_count);
   endtask : s_rctl

   task automatic s_pa(input int d, input int w, input logic pol);
      logic [31:0] c0;
      int n, lo;
      wr(IDX_DLY_HI, 32'(d >> 8));
      wr(IDX_DLY_LO, 32'(d & 255));
      wr(IDX_WID_HI, 32'(w >> 8));
      wr(IDX_WID_LO, 32'(w & 255));
      wr(IDX_TRAFFIC, {24'h0, pol, 7'h0});
      pa_pol <= pol;
      wr(IDX_RADIO_CTL, 32'h0);
      cmp("pa idle", 32'(pol), 32'(pins.power_amp_enable));
      c0 = pulse_count;
      wr(IDX_RADIO_CTL, 32'h01);
      n = 0;
      while (pulse_count === c0 && n < 6000) begin
         @(posedge clock);
         n++;
      end
      #1;
      cmp("pulse count", c0 + 32'h1, pulse_count);
      // Lead counted from the transmit pin: pulse pin lags by two
      // cycles at zero delay, tick phase adds up to three more
      lo = (d == 0) ? 2 : d * TICK - 1;
      cmp_rng("pa lead", lo, d * TICK + 2, lead_cycles);
      lo = (w - 1) * TICK + 2;
      cmp_rng("pa width", lo, w * TICK + 1, len_cycles);
   endtask : s_pa

   // Inputs at time zero, reset held 20 cycles
   initial begin
      rst = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = HSIZE_WORD;
      hwdata = 32'h0;
      serialize_start = 1'b0;
      serialize_word = 2'h0;
      gpio1_out = 1'b0;
      gpio2_out = 1'b1;
      syn_in = 1'b1;
      ga_in = 1'b0;
      gb_in = 1'b1;
      pa_pol = 1'b0;
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      repeat (2) @(posedge clock);
      #1;
      s_regs();
      s_band();
      s_ovr();
      s_rctl();
      s_pa(0, 1, 1'b0);
      s_pa(3, 2, 1'b1);
      s_pa(258, 257, 1'b0);
      test_done();
   end

   // Hang guard, well above the expected run length
   initial begin
      repeat (60000) @(posedge clock);
      n_errors++;
      test_done();
   end
endmodule : tb
